// *** logic/jis_pkg.sv ***
// Constants and types for the test-port instruction and programming unit
package jis_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register and codes
  localparam int unsigned IR_W        = 4;
  localparam logic [3:0]  IR_EXTEST   = 4'h0;
  localparam logic [3:0]  IR_IDCODE   = 4'h1;
  localparam logic [3:0]  IR_SAMPLE   = 4'h2;
  localparam logic [3:0]  IR_HIGHZ    = 4'h5;
  localparam logic [3:0]  IR_ENABLE   = 4'h9;
  localparam logic [3:0]  IR_ERASE    = 4'hA;
  localparam logic [3:0]  IR_PROGRAM  = 4'hB;
  localparam logic [3:0]  IR_VERIFY   = 4'hC;
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Data registers
  localparam int unsigned ID_W        = 32;
  // Identification value is arbitrary; bit 0 stays set as the test standard asks
  localparam logic [31:0] ID_VALUE    = 32'h0A5A_5001;
  localparam int unsigned PIN_W       = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned ROW_W       = 16;
  localparam int unsigned ISP_W       = ADDR_W + ROW_W;
  localparam int unsigned NV_ROWS     = 2 ** ADDR_W;
  localparam logic [15:0] ROW_ERASED  = 16'hFFFF;
  localparam logic [0:0]  BYP_CAPTURE = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned SYS_CLK_HZ   = 20_000_000;
  localparam int unsigned TCK_MAX_MHZ  = 10;
  localparam int unsigned ERASE_MS     = 100;
  localparam int unsigned PROGRAM_MS   = 10;
  localparam int unsigned VERIFY_US    = 10;
  localparam int unsigned ERASE_CYC_DEF   = ERASE_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned PROGRAM_CYC_DEF = PROGRAM_MS * (SYS_CLK_HZ / 1000);
  localparam int unsigned VERIFY_CYC      = VERIFY_US * (SYS_CLK_HZ / 1_000_000);
  localparam int unsigned TIMER_W      = 22;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jis_tap_t;

  typedef enum logic [1:0] {OP_NONE, OP_ERASE, OP_PROGRAM, OP_VERIFY} jis_op_t;

  typedef enum logic [1:0] {SEL_BYPASS, SEL_ID, SEL_BSR, SEL_ISP} jis_sel_t;

endpackage

// *** logic/jis_sync.sv ***
// Two-flop synchroniser for signals arriving from outside the clock domain
`timescale 1ns/1ns
module jis_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Two stages, first stage read only by the second
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;

endmodule

// *** logic/jis_tap_isp.sv ***
// Test access port with instruction decode and in-system programming sequencer
`timescale 1ns/1ns
module jis_tap_isp
  import jis_pkg::*;
#(
  parameter int unsigned ERASE_CYC   = jis_pkg::ERASE_CYC_DEF,
  parameter int unsigned PROGRAM_CYC = jis_pkg::PROGRAM_CYC_DEF
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Test port pins
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdo_oe,
  // Core logic outputs
  input  wire logic [jis_pkg::PIN_W-1:0] core_out,
  input  wire logic [jis_pkg::PIN_W-1:0] core_oe,
  // Device pins
  input  wire logic [jis_pkg::PIN_W-1:0] pin_in,
  output logic      [jis_pkg::PIN_W-1:0] pin_out,
  output logic      [jis_pkg::PIN_W-1:0] pin_oe,
  // Status
  output logic                           isp_busy
);

  import jis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation and test clock edges
  logic [2:0]       link_s;
  logic [PIN_W-1:0] pin_s;
  logic             tck_s;
  logic             tms_s;
  logic             tdi_s;
  logic             tck_prev_ff;
  logic             tck_rise;
  logic             tck_fall;

  jis_sync #(.W(3)) u_sync_link (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({tck, tms, tdi}),
    .q       (link_s)
  );

  jis_sync #(.W(PIN_W)) u_sync_pins (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (pin_in),
    .q       (pin_s)
  );

  assign tck_s    = link_s[2];
  assign tms_s    = link_s[1];
  assign tdi_s    = link_s[0];
  assign tck_rise = tck_s & ~tck_prev_ff;
  assign tck_fall = ~tck_s & tck_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // State
  jis_tap_t            tap_ff,      nxt_tap;
  logic [IR_W-1:0]     ir_sr_ff,    nxt_ir_sr;
  logic [IR_W-1:0]     ir_ff,       nxt_ir;
  logic                enable_ff,   nxt_enable;
  logic                byp_ff,      nxt_byp;
  logic [ID_W-1:0]     id_sr_ff,    nxt_id_sr;
  logic [PIN_W-1:0]    bsr_sr_ff,   nxt_bsr_sr;
  logic [PIN_W-1:0]    bsr_lat_ff,  nxt_bsr_lat;
  logic [ISP_W-1:0]    isp_sr_ff,   nxt_isp_sr;
  jis_op_t             op_ff,       nxt_op;
  logic [TIMER_W-1:0]  timer_ff,    nxt_timer;
  logic                tdo_ff,      nxt_tdo;
  logic                tdo_oe_ff,   nxt_tdo_oe;
  logic [PIN_W-1:0]    pin_out_ff,  nxt_pin_out;
  logic [PIN_W-1:0]    pin_oe_ff,   nxt_pin_oe;
  logic [ROW_W-1:0]    nv_mem [NV_ROWS];
  jis_sel_t            sel;
  jis_tap_t            tap_step;
  logic                isp_mode;
  logic                op_done;
  logic [ADDR_W-1:0]   row_addr;

  assign row_addr = isp_sr_ff[ISP_W-1 -: ADDR_W];
  assign op_done  = (op_ff != OP_NONE) && (timer_ff == '0);
  assign isp_mode = (ir_ff == IR_ENABLE) || (ir_ff == IR_ERASE) ||
                    (ir_ff == IR_PROGRAM) || (ir_ff == IR_VERIFY);

  ////////////////////////////////////////////////////////////////////////////
  // Data register selection
  always_comb
  begin
    case (ir_ff)
      IR_IDCODE:   sel = SEL_ID;
      IR_SAMPLE:   sel = SEL_BSR;
      IR_ENABLE,
      IR_ERASE,
      IR_PROGRAM,
      IR_VERIFY:   sel = SEL_ISP;
      IR_HIGHZ:    sel = SEL_BYPASS;
      default:     sel = SEL_BYPASS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port state machine step on a test clock rise
  always_comb
  begin
    case (tap_ff)
      TAP_RESET:    tap_step = tms_s ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:     tap_step = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   tap_step = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   tap_step = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_step = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_step = tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_step = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_step = tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_step = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   tap_step = tms_s ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR:   tap_step = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_step = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_step = tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_step = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_step = tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_step = tms_s ? TAP_SEL_DR : TAP_IDLE;
      default:      tap_step = TAP_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values for port, registers, operation timer and pins
  always_comb
  begin
    nxt_tap     = tap_ff;
    nxt_ir_sr   = ir_sr_ff;
    nxt_ir      = ir_ff;
    nxt_enable  = enable_ff;
    nxt_byp     = byp_ff;
    nxt_id_sr   = id_sr_ff;
    nxt_bsr_sr  = bsr_sr_ff;
    nxt_bsr_lat = bsr_lat_ff;
    nxt_isp_sr  = isp_sr_ff;
    nxt_op      = op_ff;
    nxt_timer   = timer_ff;
    nxt_tdo     = tdo_ff;
    nxt_tdo_oe  = tdo_oe_ff;

    // Actions of the current state, taken on the rising edge
    if (tck_rise)
    begin
      nxt_tap = tap_step;
      case (tap_ff)
        TAP_RESET:
        begin
          nxt_ir     = IR_IDCODE;
          nxt_enable = 1'b0;
        end
        TAP_CAP_IR:   nxt_ir_sr = IR_CAPTURE;
        TAP_SHIFT_IR: nxt_ir_sr = {tdi_s, ir_sr_ff[IR_W-1:1]};
        TAP_CAP_DR:
        begin
          nxt_byp    = BYP_CAPTURE;
          nxt_id_sr  = ID_VALUE;
          nxt_bsr_sr = pin_s;
        end
        TAP_SHIFT_DR:
        begin
          case (sel)
            SEL_ID:  nxt_id_sr  = {tdi_s, id_sr_ff[ID_W-1:1]};
            SEL_BSR: nxt_bsr_sr = {tdi_s, bsr_sr_ff[PIN_W-1:1]};
            SEL_ISP:
              if (op_ff == OP_NONE)
                nxt_isp_sr = {tdi_s, isp_sr_ff[ISP_W-1:1]};
            default: nxt_byp    = tdi_s;
          endcase
        end
        TAP_UPD_DR:
          if (sel == SEL_BSR)
            nxt_bsr_lat = bsr_sr_ff;
        default: ;
      endcase

      // New instruction active on entering Update-IR, so the rise into Idle sees it
      if (tap_step == TAP_UPD_IR)
      begin
        nxt_ir = ir_sr_ff;
        if (ir_sr_ff == IR_ENABLE)
          nxt_enable = 1'b1;
      end

      // Command start on entering Run-Test/Idle, only once enabled
      if ((tap_step == TAP_IDLE) && (tap_ff != TAP_IDLE) && enable_ff &&
          (op_ff == OP_NONE))
      begin
        case (ir_ff)
          IR_ERASE:
          begin
            nxt_op    = OP_ERASE;
            nxt_timer = TIMER_W'(ERASE_CYC - 1);
          end
          IR_PROGRAM:
          begin
            nxt_op    = OP_PROGRAM;
            nxt_timer = TIMER_W'(PROGRAM_CYC - 1);
          end
          IR_VERIFY:
          begin
            nxt_op    = OP_VERIFY;
            nxt_timer = TIMER_W'(VERIFY_CYC - 1);
          end
          default: ;
        endcase
      end
    end

    // Data out changes only on the falling edge
    if (tck_fall)
    begin
      nxt_tdo_oe = (tap_ff == TAP_SHIFT_DR) || (tap_ff == TAP_SHIFT_IR);
      if (tap_ff == TAP_SHIFT_IR)
        nxt_tdo = ir_sr_ff[0];
      else
      begin
        case (sel)
          SEL_ID:  nxt_tdo = id_sr_ff[0];
          SEL_BSR: nxt_tdo = bsr_sr_ff[0];
          SEL_ISP: nxt_tdo = isp_sr_ff[0];
          default: nxt_tdo = byp_ff;
        endcase
      end
    end

    // Operation timer, runs on the system clock
    if (op_ff != OP_NONE)
    begin
      if (op_done)
      begin
        nxt_op = OP_NONE;
        if (op_ff == OP_VERIFY)
          nxt_isp_sr = {row_addr, nv_mem[row_addr]};
      end
      else
        nxt_timer = timer_ff - 1'b1;
    end

    // Pin drive selection
    if (ir_ff == IR_HIGHZ)
    begin
      nxt_pin_out = core_out;
      nxt_pin_oe  = '0;
    end
    else if (isp_mode)
    begin
      nxt_pin_out = bsr_lat_ff;
      nxt_pin_oe  = '1;
    end
    else
    begin
      nxt_pin_out = core_out;
      nxt_pin_oe  = core_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tap_ff      <= TAP_RESET;
      tck_prev_ff <= 1'b0;
      ir_sr_ff    <= IR_CAPTURE;
      ir_ff       <= IR_IDCODE;
      enable_ff   <= 1'b0;
      byp_ff      <= 1'b0;
      id_sr_ff    <= '0;
      bsr_sr_ff   <= '0;
      bsr_lat_ff  <= '0;
      isp_sr_ff   <= '0;
      op_ff       <= OP_NONE;
      timer_ff    <= '0;
      tdo_ff      <= 1'b0;
      tdo_oe_ff   <= 1'b0;
      pin_out_ff  <= '0;
      pin_oe_ff   <= '0;
    end
    else
    begin
      tap_ff      <= nxt_tap;
      tck_prev_ff <= tck_s;
      ir_sr_ff    <= nxt_ir_sr;
      ir_ff       <= nxt_ir;
      enable_ff   <= nxt_enable;
      byp_ff      <= nxt_byp;
      id_sr_ff    <= nxt_id_sr;
      bsr_sr_ff   <= nxt_bsr_sr;
      bsr_lat_ff  <= nxt_bsr_lat;
      isp_sr_ff   <= nxt_isp_sr;
      op_ff       <= nxt_op;
      timer_ff    <= nxt_timer;
      tdo_ff      <= nxt_tdo;
      tdo_oe_ff   <= nxt_tdo_oe;
      pin_out_ff  <= nxt_pin_out;
      pin_oe_ff   <= nxt_pin_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile array, kept through reset
  always_ff @(posedge sys_clk)
  begin
    if (!rst && op_done)
    begin
      if (op_ff == OP_ERASE)
      begin
        for (int i = 0; i < NV_ROWS; i++)
          nv_mem[i] <= ROW_ERASED;
      end
      else if (op_ff == OP_PROGRAM)
        nv_mem[row_addr] <= isp_sr_ff[ROW_W-1:0];
    end
  end

  // Outputs
  assign tdo      = tdo_ff;
  assign tdo_oe   = tdo_oe_ff;
  assign pin_out  = pin_out_ff;
  assign pin_oe   = pin_oe_ff;
  assign isp_busy = (op_ff != OP_NONE);

endmodule

// *** test/jis_tap_isp_checker.sv ***
// Port checker for the test-port instruction and programming unit
`timescale 1ns/1ns
module jis_tap_isp_checker
  import jis_pkg::*;
#(
  parameter int unsigned ERASE_CYC   = 20,
  parameter int unsigned PROGRAM_CYC = 10
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  // Test port
  input  wire logic                      tck,
  input  wire logic                      tdo,
  input  wire logic                      tdo_oe,
  // Pins and status
  input  wire logic [jis_pkg::PIN_W-1:0] pin_out,
  input  wire logic [jis_pkg::PIN_W-1:0] pin_oe,
  input  wire logic                      isp_busy
);
  import jis_pkg::*;

  logic [21:0] busy_ff;
  logic [21:0] nxt_busy;

  ////////////////////////////////////////////////////////////////////////////
  // Length of the current busy spell
  always_comb
  begin
    nxt_busy = isp_busy ? busy_ff + 22'h1 : 22'h0;
  end

  always_ff @(posedge sys_clk)
  begin
    busy_ff <= rst ? 22'h0 : nxt_busy;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Serial output timing
  a_tdo_after_fall: assert property ($changed(tdo) |-> !$past(tck, 2))
    else $error("tdo moved while tck was high");
  a_oe_on_fall: assert property ($rose(tdo_oe) |-> !$past(tck, 2))
    else $error("tdo_oe rose while tck was high");
  a_oe_off_fall: assert property ($fell(tdo_oe) |-> !$past(tck, 2))
    else $error("tdo_oe fell while tck was high");

  ////////////////////////////////////////////////////////////////////////////
  // Reset and programming operations
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !tdo_oe && pin_oe == 8'h00 && !isp_busy)
    else $error("outputs active after reset");
  a_busy_pins_held: assert property (isp_busy |-> pin_oe == 8'hFF)
    else $error("pins not all driven during operation");
  a_busy_pins_stable: assert property (isp_busy && $past(isp_busy) |-> $stable(pin_out))
    else $error("pin values moved during operation");
  a_busy_length: assert property ($fell(isp_busy) |-> busy_ff inside {ERASE_CYC, PROGRAM_CYC, VERIFY_CYC})
    else $error("operation time wrong");
  a_busy_after_rise: assert property ($rose(isp_busy) |-> $past(tck, 2))
    else $error("operation started away from a tck rise");

  // Main scenarios
  c_busy: cover property ($rose(isp_busy));
  c_shift: cover property ($rose(tdo_oe));
  c_highz: cover property (pin_oe == 8'h00);
endmodule

bind jis_tap_isp jis_tap_isp_checker #(.ERASE_CYC(ERASE_CYC), .PROGRAM_CYC(PROGRAM_CYC)) i_chk (
  .sys_clk(sys_clk), .rst(rst), .tck(tck), .tdo(tdo), .tdo_oe(tdo_oe),
  .pin_out(pin_out), .pin_oe(pin_oe), .isp_busy(isp_busy));

// *** test/jis_host.sv ***
// Behavioural test-port controller driving clock, mode and data pins
`timescale 1ns/1ns
module jis_host (
  // Clock
  input  wire logic sys_clk,
  // Test port pins
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One 400 ns test clock: fall with new mode and data, rise, read data out
  task automatic tick(input logic m, input logic d, output logic q);
    @(posedge sys_clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge sys_clk);
    tck <= 1'b1;
    repeat (3) @(posedge sys_clk);
    q = tdo;
  endtask

  // Five high mode bits reach Test-Logic-Reset, then park in Run-Test/Idle
  task automatic tap_reset();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask

  // IR or DR scan from Idle, LSB first, then idle for the operation time
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      input int idle, output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    tick(1'b1, 1'b0, q);
    if (ir)
      tick(1'b1, 1'b0, q);
    repeat (2) tick(1'b0, 1'b0, q);
    for (int k = 0; k < n; k++)
    begin
      tick(k == n - 1, din[k], q);
      dout[k] = q;
    end
    tick(1'b1, 1'b0, q);
    repeat (idle + 1) tick(1'b0, 1'b0, q);
  endtask
endmodule

// *** test/jis_tap_isp_bench.sv ***
// Self-checking bench for the test-port instruction and programming unit
`timescale 1ns/1ns
module jis_tap_isp_bench;
  import jis_pkg::*;
  localparam int unsigned EC = 20;
  localparam int unsigned PC = 10;

  logic             sys_clk   = 1'b0;
  logic             rst       = 1'b1;
  logic             tck;
  logic             tms;
  logic             tdi;
  logic             tdo;
  logic             tdo_oe;
  logic             tdo_line;
  logic [PIN_W-1:0] core_out  = 8'h3C;
  logic [PIN_W-1:0] core_oe   = 8'hF0;
  logic [PIN_W-1:0] pin_in    = 8'h96;
  logic [PIN_W-1:0] pin_out;
  logic [PIN_W-1:0] pin_oe;
  logic             isp_busy;
  logic [31:0]      rd;
  int               busy_cyc  = 0;
  int               err_count = 0;
  int               tests_run = 0;

  always #25 sys_clk = ~sys_clk;

  // Cycles spent busy so far
  always @(posedge sys_clk)
    if (isp_busy === 1'b1)
      busy_cyc <= busy_cyc + 1;

  jis_tap_isp #(.ERASE_CYC(EC), .PROGRAM_CYC(PC)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .isp_busy(isp_busy));

  // Pull-up holds the data line high while the port leaves it undriven
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  jis_host i_host (.sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_line));

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and verdict
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (err_count == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Identification after power-up and instruction capture
  task automatic t_idcode();
    check("pin_out", pin_out, core_out);
    i_host.scan(1'b0, 32, 32'h0, 0, rd);
    check("id", rd, ID_VALUE);
    check("tdo_oe", tdo_oe, 1'b0);
    i_host.scan(1'b1, 4, IR_IDCODE, 0, rd);
    check("ir capture", rd, IR_CAPTURE);
    i_host.scan(1'b0, 32, 32'h0, 0, rd);
    check("id", rd, ID_VALUE);
  endtask

  // One-stage pass-through for bypass and unlisted codes
  task automatic t_bypass();
    logic [3:0] codes [2] = '{IR_BYPASS, IR_EXTEST};
    foreach (codes[i])
    begin
      i_host.scan(1'b1, 4, codes[i], 0, rd);
      i_host.scan(1'b0, 8, 32'hA5, 0, rd);
      check("bypass", rd, 32'h4A);
    end
  endtask

  // Outputs released and bypass selected under high impedance
  task automatic t_highz();
    i_host.scan(1'b1, 4, IR_HIGHZ, 0, rd);
    check("pin_oe", pin_oe, 8'h00);
    i_host.scan(1'b0, 8, 32'h3C, 0, rd);
    check("highz bypass", rd, 32'h78);
    check("pin_oe", pin_oe, 8'h00);
  endtask

  // Commands without an enable are ignored
  task automatic t_refused();
    logic [3:0] codes [3] = '{IR_ERASE, IR_PROGRAM, IR_VERIFY};
    int b0;
    foreach (codes[i])
    begin
      b0 = busy_cyc;
      i_host.scan(1'b1, 4, codes[i], EC / 8 + 3, rd);
      check("locked busy", busy_cyc - b0, 32'h0);
    end
  endtask

  // Pin sampling and preload
  task automatic t_preload();
    i_host.scan(1'b1, 4, IR_SAMPLE, 0, rd);
    check("pin_out", pin_out, core_out);
    i_host.scan(1'b0, 8, 32'h5A, 0, rd);
    check("sample", rd, 32'h96);
  endtask

  // Enable, erase, program, verify, then lock again by Test-Logic-Reset
  task automatic t_program();
    int b0;
    i_host.scan(1'b1, 4, IR_ENABLE, 0, rd);
    check("pin_out", pin_out, 8'h5A);
    check("pin_oe", pin_oe, 8'hFF);
    b0 = busy_cyc;
    i_host.scan(1'b1, 4, IR_ERASE, EC / 8 + 3, rd);
    check("erase busy", busy_cyc - b0, EC);
    i_host.scan(1'b1, 4, IR_ENABLE, 0, rd);
    i_host.scan(1'b0, 20, 32'h31234, 0, rd);
    b0 = busy_cyc;
    i_host.scan(1'b1, 4, IR_PROGRAM, PC / 8 + 3, rd);
    check("program busy", busy_cyc - b0, PC);
    b0 = busy_cyc;
    i_host.scan(1'b1, 4, IR_VERIFY, VERIFY_CYC / 8 + 3, rd);
    check("verify busy", busy_cyc - b0, VERIFY_CYC);
    i_host.scan(1'b0, 20, 32'h0, VERIFY_CYC / 8 + 3, rd);
    check("row 3", rd, 32'h31234);
    i_host.scan(1'b1, 4, IR_ENABLE, 0, rd);
    i_host.scan(1'b0, 20, 32'h50000, 0, rd);
    i_host.scan(1'b1, 4, IR_VERIFY, VERIFY_CYC / 8 + 3, rd);
    i_host.scan(1'b0, 20, 32'h0, VERIFY_CYC / 8 + 3, rd);
    check("row 5", rd, {12'h0, 4'h5, ROW_ERASED});
    i_host.tap_reset();
    b0 = busy_cyc;
    i_host.scan(1'b1, 4, IR_PROGRAM, PC / 8 + 3, rd);
    check("relocked busy", busy_cyc - b0, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    i_host.tap_reset();
    t_idcode();
    t_bypass();
    t_highz();
    t_refused();
    t_preload();
    t_program();
    final_report();
  end

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    final_report();
  end
endmodule
